// ==== pkg/angle_pwm_cfg.svh ====
// Constants for the angle to duty-cycle mapper
`ifndef ANGLE_PWM_CFG_SVH
`define ANGLE_PWM_CFG_SVH
`define CLK_MHZ          125
`define UV_DET_US        50
`define UV_REC_US        50
`define OV_DET_US        50
`define OV_REC_US        50
`define WD_LIMIT_MS      12
`define PWM_DIV_DEF      4
`define OFS_CTRL         8'h00
`define OFS_START        8'h04
`define OFS_END          8'h08
`define OFS_DUTY_START   8'h0c
`define OFS_DUTY_END     8'h10
`define OFS_CLAMP        8'h14
`define OFS_WRAP         8'h18
`define OFS_STATUS       8'h1c
`define OFS_MASK         8'h20
`define OFS_STATE        8'h24
`define CTRL_INVERT      0
`define CTRL_DIAG_HIGH   1
`define CTRL_DIAG_FLOAT  2
`define CTRL_LOCK        3
`define CLAMP_HIGH_POS   16
`define EV_UV            0
`define EV_OV            1
`define EV_WD            2
`define EV_RECOVER       3
`define RST_START        14'h0000
`define RST_END          14'h3fff
`define RST_DUTY_START   12'h100
`define RST_DUTY_END     12'hf00
`define RST_CLAMP_LOW    9'h020
`define RST_CLAMP_HIGH   9'h1e0
`define RST_WRAP         14'h0000
`define FAIL_DUTY_LOW    12'h052
`define FAIL_DUTY_HIGH   12'hfad
`endif

// ==== pkg/angle_pwm_pkg.sv ====
// Types shared by the angle to duty-cycle mapper
package angle_pwm_pkg;
	typedef struct packed {
		logic        invert;
		logic        diag_high;
		logic        diag_float;
		logic [13:0] angle_start_point;
		logic [13:0] angle_end_point;
		logic [11:0] duty_at_start;
		logic [11:0] duty_at_end;
		logic [8:0]  clamp_level_low;
		logic [8:0]  clamp_level_high;
		logic [13:0] wrap_point;
	} map_cfg_s;

	typedef struct packed {
		logic        under_q;
		logic        over_q;
		logic [15:0] under_cnt;
		logic [15:0] over_cnt;
		logic [20:0] wd_cnt;
		logic        wd_err;
	} mon_s;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_RD1  = 2'b01,
		BUS_RD2  = 2'b11,
		BUS_WR   = 2'b10
	} bus_st_e;
endpackage

// ==== hdl/angle_to_pwm_mapper.sv ====
// Angle to duty-cycle mapper with supply monitor and AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "angle_pwm_cfg.svh"
module angle_to_pwm_mapper
	import angle_pwm_pkg::*;
#(
	parameter int UV_DET_CYC = `UV_DET_US * `CLK_MHZ,
	parameter int UV_REC_CYC = `UV_REC_US * `CLK_MHZ,
	parameter int OV_DET_CYC = `OV_DET_US * `CLK_MHZ,
	parameter int OV_REC_CYC = `OV_REC_US * `CLK_MHZ,
	parameter int WD_CYC     = `WD_LIMIT_MS * 1000 * `CLK_MHZ,
	parameter int PWM_DIV    = `PWM_DIV_DEF
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Angle source and alarms
	input  wire logic [13:0] angle_code,
	input  wire logic        angle_valid,
	input  wire logic        internal_alarm,
	// Supply comparators
	input  wire logic        under_flag,
	input  wire logic        over_flag,
	// Open-drain output pin
	output logic             out_o,
	output logic             out_oe,
	// Interrupt
	output logic             irq
);
	localparam logic [15:0] UV_DET = 16'(UV_DET_CYC);
	localparam logic [15:0] UV_REC = 16'(UV_REC_CYC);
	localparam logic [15:0] OV_DET = 16'(OV_DET_CYC);
	localparam logic [15:0] OV_REC = 16'(OV_REC_CYC);
	localparam logic [20:0] WD_LIM = 21'(WD_CYC);
	localparam logic [7:0]  DIV    = 8'(PWM_DIV);

	// Persistence filter: returns {flip, next count}
	function automatic logic [16:0] qualify(input logic want,
		input logic [15:0] cnt, input logic [15:0] lim);
		logic [16:0] r;
		r = {1'b0, 16'h0000};
		if (want) begin
			if (cnt >= lim - 16'h0001)
				r = {1'b1, 16'h0000};
			else
				r = {1'b0, cnt + 16'h0001};
		end
		return r;
	endfunction

	// Transfer characteristic from angle code to 12-bit duty
	function automatic logic [11:0] map_duty(input logic [13:0] ang,
		input map_cfg_s c);
		logic [13:0]        a;
		logic [13:0]        s;
		logic [13:0]        span;
		logic signed [14:0] off;
		logic signed [12:0] dy;
		logic signed [28:0] prod;
		logic signed [28:0] y;
		logic [11:0]        lo;
		logic [11:0]        hi;
		a    = (c.invert ? ~ang : ang) - c.wrap_point;
		s    = c.angle_start_point - c.wrap_point;
		span = (c.angle_end_point - c.wrap_point) - s;
		off  = $signed({1'b0, a}) - $signed({1'b0, s});
		dy   = $signed({1'b0, c.duty_at_end}) - $signed({1'b0, c.duty_at_start});
		lo   = {c.clamp_level_low, 3'h0};
		hi   = {c.clamp_level_high, 3'h0};
		prod = 29'(off * dy);
		if (span == 14'h0000)
			y = $signed({17'h00000, c.duty_at_start});
		else
			y = 29'(prod / $signed({15'h0000, span}))
				+ $signed({17'h00000, c.duty_at_start});
		if (y < $signed({17'h00000, lo}))
			return lo;
		if (y > $signed({17'h00000, hi}))
			return hi;
		return y[11:0];
	endfunction

	// Bus and register state
	bus_st_e     bus_q, bus_d;
	logic [7:0]  addr_q, addr_d;
	logic [31:0] rdata_q, rdata_d;
	map_cfg_s    cfg_q, cfg_d;
	logic        locked_q, locked_d;
	logic [3:0]  status_q, status_d;
	logic [3:0]  mask_q, mask_d;
	logic [3:0]  events;
	logic        accept;
	// Monitor and output state
	mon_s        mon_q, mon_d;
	logic [16:0] uv_step, ov_step;
	logic        supply_ok, failed, drive_en;
	logic [7:0]  div_q, div_d;
	logic [11:0] cnt_q, cnt_d;
	logic [11:0] duty_q, duty_d;
	logic [11:0] mapped;
	logic [13:0] angle_q, angle_d;
	logic        tick;

	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			`OFS_CTRL: begin
				w[`CTRL_INVERT]     = cfg_q.invert;
				w[`CTRL_DIAG_HIGH]  = cfg_q.diag_high;
				w[`CTRL_DIAG_FLOAT] = cfg_q.diag_float;
				w[`CTRL_LOCK]       = locked_q;
			end
			`OFS_START:      w[13:0] = cfg_q.angle_start_point;
			`OFS_END:        w[13:0] = cfg_q.angle_end_point;
			`OFS_DUTY_START: w[11:0] = cfg_q.duty_at_start;
			`OFS_DUTY_END:   w[11:0] = cfg_q.duty_at_end;
			`OFS_CLAMP: begin
				w[8:0] = cfg_q.clamp_level_low;
				w[`CLAMP_HIGH_POS +: 9] = cfg_q.clamp_level_high;
			end
			`OFS_WRAP:   w[13:0] = cfg_q.wrap_point;
			`OFS_STATUS: w[3:0]  = status_q;
			`OFS_MASK:   w[3:0]  = mask_q;
			`OFS_STATE:  w = {14'h0000, mon_q.wd_err, mon_q.over_q,
				mon_q.under_q, drive_en, angle_q};
			default:     w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	assign accept    = hsel & htrans[1] & hready;
	assign hreadyout = (bus_q != BUS_RD1);
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;
	assign irq       = |(status_q & mask_q);

	// Bus, configuration and interrupt next state
	always_comb begin
		bus_d    = bus_q;
		addr_d   = addr_q;
		rdata_d  = rdata_q;
		cfg_d    = cfg_q;
		locked_d = locked_q;
		mask_d   = mask_q;
		status_d = status_q;
		if (bus_q == BUS_RD1) begin
			rdata_d = rd_word(addr_q);
			bus_d   = BUS_RD2;
		end else if (accept) begin
			addr_d = {haddr[7:2], 2'b00};
			bus_d  = hwrite ? BUS_WR : BUS_RD1;
		end else begin
			bus_d = BUS_IDLE;
		end
		if (bus_q == BUS_WR) begin
			if (!locked_q) begin
				case (addr_q)
					`OFS_CTRL: begin
						cfg_d.invert     = hwdata[`CTRL_INVERT];
						cfg_d.diag_high  = hwdata[`CTRL_DIAG_HIGH];
						cfg_d.diag_float = hwdata[`CTRL_DIAG_FLOAT];
						locked_d         = hwdata[`CTRL_LOCK];
					end
					`OFS_START:      cfg_d.angle_start_point = hwdata[13:0];
					`OFS_END:        cfg_d.angle_end_point   = hwdata[13:0];
					`OFS_DUTY_START: cfg_d.duty_at_start     = hwdata[11:0];
					`OFS_DUTY_END:   cfg_d.duty_at_end       = hwdata[11:0];
					`OFS_CLAMP: begin
						cfg_d.clamp_level_low  = hwdata[8:0];
						cfg_d.clamp_level_high = hwdata[`CLAMP_HIGH_POS +: 9];
					end
					`OFS_WRAP:       cfg_d.wrap_point = hwdata[13:0];
					default:         cfg_d = cfg_q;
				endcase
			end
			if (addr_q == `OFS_MASK)
				mask_d = hwdata[3:0];
			if (addr_q == `OFS_STATUS)
				status_d = status_q & ~hwdata[3:0];
		end
		status_d = status_d | events;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q    <= BUS_IDLE;
			addr_q   <= 8'h00;
			rdata_q  <= 32'h0000_0000;
			cfg_q    <= '{1'b0, 1'b0, 1'b0, `RST_START, `RST_END,
				`RST_DUTY_START, `RST_DUTY_END, `RST_CLAMP_LOW,
				`RST_CLAMP_HIGH, `RST_WRAP};
			locked_q <= 1'b0;
			status_q <= 4'h0;
			mask_q   <= 4'h0;
		end else begin
			bus_q    <= bus_d;
			addr_q   <= addr_d;
			rdata_q  <= rdata_d;
			cfg_q    <= cfg_d;
			locked_q <= locked_d;
			status_q <= status_d;
			mask_q   <= mask_d;
		end
	end

	// Supply monitor and watchdog next state
	always_comb begin
		mon_d   = mon_q;
		uv_step = qualify(under_flag != mon_q.under_q, mon_q.under_cnt,
			mon_q.under_q ? UV_REC : UV_DET);
		ov_step = qualify(over_flag != mon_q.over_q, mon_q.over_cnt,
			mon_q.over_q ? OV_REC : OV_DET);
		mon_d.under_cnt = uv_step[15:0];
		mon_d.over_cnt  = ov_step[15:0];
		if (uv_step[16])
			mon_d.under_q = ~mon_q.under_q;
		if (ov_step[16])
			mon_d.over_q = ~mon_q.over_q;
		if (angle_valid) begin
			mon_d.wd_cnt = 21'h000000;
			mon_d.wd_err = 1'b0;
		end else if (mon_q.wd_cnt >= WD_LIM - 21'h000001) begin
			mon_d.wd_err = 1'b1;
		end else begin
			mon_d.wd_cnt = mon_q.wd_cnt + 21'h000001;
		end
		events = 4'h0;
		events[`EV_UV] = mon_d.under_q & ~mon_q.under_q;
		events[`EV_OV] = mon_d.over_q & ~mon_q.over_q;
		events[`EV_WD] = mon_d.wd_err & ~mon_q.wd_err;
		events[`EV_RECOVER] = (mon_q.under_q | mon_q.over_q)
			& ~mon_d.under_q & ~mon_d.over_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			mon_q <= '{1'b0, 1'b0, 16'h0000, 16'h0000, 21'h000000, 1'b0};
		else
			mon_q <= mon_d;
	end

	// Output path: angle capture, mapping and duty-cycle generator
	assign supply_ok = ~mon_q.under_q & ~mon_q.over_q;
	assign failed    = mon_q.wd_err | internal_alarm;
	assign drive_en  = supply_ok & ~(failed & cfg_q.diag_float);
	assign mapped    = map_duty(angle_q, cfg_q);
	assign tick      = (div_q == DIV - 8'h01);
	assign out_o     = 1'b0;
	assign out_oe    = drive_en & ~(cnt_q < duty_q);

	always_comb begin
		angle_d = angle_valid ? angle_code : angle_q;
		div_d   = tick ? 8'h00 : div_q + 8'h01;
		cnt_d   = tick ? cnt_q + 12'h001 : cnt_q;
		duty_d  = duty_q;
		if (tick && cnt_q == 12'hfff) begin
			if (failed)
				duty_d = cfg_q.diag_high ? `FAIL_DUTY_HIGH
					: `FAIL_DUTY_LOW;
			else
				duty_d = mapped;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			angle_q <= 14'h0000;
			div_q   <= 8'h00;
			cnt_q   <= 12'h000;
			duty_q  <= 12'h000;
		end else begin
			angle_q <= angle_d;
			div_q   <= div_d;
			cnt_q   <= cnt_d;
			duty_q  <= duty_d;
		end
	end
endmodule
`default_nettype wire

// ==== bench/angle_pwm_props.sv ====
// Port assertions for the angle to duty-cycle mapper
`timescale 1ns/1ps
`default_nettype none
module angle_pwm_props (
	// Clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// Bus
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	// Supply and pin
	input wire logic       under_flag,
	input wire logic       over_flag,
	input wire logic       out_o,
	input wire logic       out_oe
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay)
		else $error("bus response not okay");
	property p_wr_wait;
		hsel && htrans[1] && hready && hwrite |=> hreadyout;
	endproperty
	a_wr_wait: assert property (p_wr_wait)
		else $error("write stalled");
	property p_rd_wait;
		hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("read wait state wrong");
	property p_drive_low;
		out_o == 1'b0;
	endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("pin driven high");
	property p_uv_off;
		under_flag [*8] ##1 under_flag [*3] |-> !out_oe;
	endproperty
	a_uv_off: assert property (p_uv_off)
		else $error("pin active in undervoltage");
	property p_ov_off;
		over_flag [*8] ##1 over_flag [*3] |-> !out_oe;
	endproperty
	a_ov_off: assert property (p_ov_off)
		else $error("pin active in overvoltage");
	property p_uv_rec;
		under_flag [*8] ##1 under_flag [*3] ##1 !under_flag [*5] |-> !out_oe;
	endproperty
	a_uv_rec: assert property (p_uv_rec)
		else $error("undervoltage recovery too early");
	property p_ov_rec;
		over_flag [*8] ##1 over_flag [*3] ##1 !over_flag [*5] |-> !out_oe;
	endproperty
	a_ov_rec: assert property (p_ov_rec)
		else $error("overvoltage recovery too early");
endmodule
bind angle_to_pwm_mapper angle_pwm_props u_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .under_flag(under_flag), .over_flag(over_flag),
	.out_o(out_o), .out_oe(out_oe)
);
`default_nettype wire

// ==== bench/duty_decoder.sv ====
// Far-side controller model that measures pin high time per period
`timescale 1ns/1ps
`default_nettype none
module duty_decoder #(
	parameter int WIN = 4096
) (
	// Clock and pin
	input wire logic        hclk,
	input wire logic        pin,
	// Result
	output logic     [12:0] duty_seen,
	output logic            done
);
	logic [12:0] cnt_q = '0;
	logic [12:0] acc_q = '0;
	// Window equals the period, so any phase sums one whole period
	always_ff @(posedge hclk) begin
		done <= 1'b0;
		if (cnt_q == 13'(WIN - 1)) begin
			duty_seen <= acc_q + 13'(pin);
			acc_q <= '0;
			cnt_q <= '0;
			done <= 1'b1;
		end else begin
			acc_q <= acc_q + 13'(pin);
			cnt_q <= cnt_q + 13'h1;
		end
	end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Testbench for the angle to duty-cycle mapper
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        hclk, hresetn, hwrite, angle_valid, internal_alarm;
	logic        under_flag, over_flag, hreadyout, out_oe, irq, pin, done;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0]  htrans;
	logic [13:0] angle_code;
	logic [12:0] duty_seen;
	logic        hsel;
	logic [2:0]  hsize;
	int          err_count, tests_run, i;
	logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
		8'h18, 8'h30};
	logic [31:0] rx [8] = '{32'h0, 32'h0, 32'h3fff, 32'h100, 32'hf00,
		32'h01e00020, 32'h0, 32'h0};

	assign pin = out_oe ? 1'b0 : 1'b1;

	// Overvoltage recovery keeps its full default length
	angle_to_pwm_mapper #(.UV_DET_CYC(8), .UV_REC_CYC(8), .OV_DET_CYC(8),
		.WD_CYC(50), .PWM_DIV(1)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .angle_code(angle_code),
		.angle_valid(angle_valid), .internal_alarm(internal_alarm),
		.under_flag(under_flag), .over_flag(over_flag), .out_o(),
		.out_oe(out_oe), .irq(irq));
	duty_decoder u_dec (.hclk(hclk), .pin(pin), .duty_seen(duty_seen),
		.done(done));

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// Samples ready at the falling edge, then lands on the rising edge
	task automatic rdy(output logic [31:0] d);
		int n;
		n = 0;
		@(negedge hclk);
		while (hreadyout !== 1'b1 && n < 100) begin
			n++;
			@(negedge hclk);
		end
		if (n == 100) begin
			err_count++;
			print_verdict();
		end
		d = hrdata;
		@(posedge hclk);
	endtask
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] d);
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		rdy(d);
		htrans <= 2'b00;
		hwdata <= wd;
		rdy(d);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(a, 1'b1, d, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		xfer(a, 1'b0, 32'h0, d);
	endtask
	// Third window after a change holds one whole updated period
	task automatic map(input string nm, input logic [13:0] a,
		input logic [31:0] e);
		int k, n;
		angle_code <= a;
		k = 0;
		n = 0;
		while (k < 3 && n < 15000) begin
			@(negedge hclk);
			n++;
			if (done === 1'b1)
				k++;
		end
		if (k < 3) begin
			err_count++;
			print_verdict();
		end
		chk(nm, e, {19'h0, duty_seen});
		@(posedge hclk);
		$display("test %s done", nm);
	endtask
	task automatic sup(input int s, input int n);
		if (s == 0)
			under_flag <= 1'b1;
		else
			over_flag <= 1'b1;
		repeat (n) @(posedge hclk);
		under_flag <= 1'b0;
		over_flag <= 1'b0;
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		hsize = 3'b010;
		haddr = '0;
		htrans = '0;
		hwrite = 1'b0;
		hwdata = '0;
		angle_code = '0;
		angle_valid = 1'b1;
		internal_alarm = 1'b0;
		under_flag = 1'b0;
		over_flag = 1'b0;
		err_count = 0;
		tests_run = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (ra[j]) begin
			rd(ra[j], rv);
			chk("reset value", rx[j], rv);
		end
		wr(8'h04, 32'hffffffff);
		rd(8'h04, rv);
		chk("start width", 32'h3fff, rv);
		wr(8'h04, 32'h0);
		hsel <= 1'b0;
		wr(8'h04, 32'h55);
		hsel <= 1'b1;
		rd(8'h04, rv);
		chk("unselected write", 32'h0, rv);
		$display("test registers done");
		map("mid", 14'h2000, 32'h100 + 32'h2000 * 32'he00 / 32'h3fff);
		wr(8'h14, 32'h01e00040);
		map("clamp", 14'h0400, 32'h200);
		wr(8'h00, 32'h1);
		map("invert", 14'h0400, 32'h100 + 32'h3bff * 32'he00 / 32'h3fff);
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h1000);
		wr(8'h18, 32'h1000);
		map("wrap", 14'h0800, 32'hf00);
		wr(8'h00, 32'h2);
		internal_alarm <= 1'b1;
		map("fail high", 14'h0800, 32'hfad);
		wr(8'h00, 32'h4);
		map("fail float", 14'h0800, 32'h1000);
		internal_alarm <= 1'b0;
		wr(8'h20, 32'hf);
		for (i = 0; i < 2; i++) begin
			sup(i, 4);
			rd(8'h1c, rv);
			chk("glitch", 32'h0, rv);
			sup(i, 12);
			chk("irq", 32'h1, {31'h0, irq});
			rd(8'h1c, rv);
			chk("qualified", 32'h1 << i, rv);
			rd(8'h24, rv);
			chk("state", 32'h800 | (32'h8000 << i), rv);
			repeat (i == 0 ? 12 : 6250) @(posedge hclk);
			rd(8'h1c, rv);
			chk("recovered", (32'h1 << i) | 32'h8, rv);
			wr(8'h1c, 32'hf);
			rd(8'h1c, rv);
			chk("cleared", 32'h0, rv);
			chk("irq off", 32'h0, {31'h0, irq});
		end
		$display("test supply done");
		wr(8'h20, 32'hb);
		angle_valid <= 1'b0;
		repeat (60) @(posedge hclk);
		angle_valid <= 1'b1;
		rd(8'h1c, rv);
		chk("watchdog", 32'h4, rv);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(8'h20, 32'hf);
		rd(8'h1c, rv);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(8'h1c, 32'hf);
		$display("test watchdog done");
		wr(8'h00, 32'h8);
		wr(8'h04, 32'h0123);
		rd(8'h04, rv);
		chk("locked start", 32'h1000, rv);
		rd(8'h00, rv);
		chk("lock bit", 32'h8, rv);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(8'h04, rv);
		chk("start default", 32'h0, rv);
		rd(8'h00, rv);
		chk("unlocked", 32'h0, rv);
		$display("test lock done");
		print_verdict();
	end
endmodule
`default_nettype wire
